// ---- design/acg_regs.sv ----
`timescale 1ns/1ps
module acg_regs #(
   parameter int NCH = 16,
   parameter logic [15:0] ID_VALUE = 16'h5A50 // Arbitrary identification value
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Register port
   input wire acg_pkg::acg_bus_req_t bus_req,
   output logic [acg_pkg::ACG_DW-1:0] reg_rdata,
   // General pins
   input wire logic [1:0] general_pin_in,
   output acg_pkg::acg_pin_t general_pin,
   // Conversion engine
   input wire logic conv_done,
   output acg_pkg::acg_seq_t seq_now,
   output logic [15:0] channel_enable_mask
);
   import acg_pkg::*;

   // Whole state of the block in one place
   typedef struct packed {
      acg_chan_t [NCH-1:0] chan;
      acg_gpio_t gpio;
      logic [1:0] sync1;
      logic [1:0] sync2;
      logic [3:0] cur;
      acg_seq_t seq;
      logic [15:0] mask;
      acg_pin_t pin;
      logic [15:0] rdata;
   } acg_state_t;

   acg_state_t st_q;
   acg_state_t st_d;

   // Reset image of the state
   localparam acg_chan_t CH_RST = ACG_CH_RESET;
   localparam acg_seq_t SEQ_RST = '{channel: 4'h0, en: CH_RST.en,
      setup: CH_RST.setup, pair: CH_RST.pair};

   function automatic acg_state_t reset_state();
      acg_state_t s;
      s = '0;
      for (int i = 0; i < NCH; i++) begin
         s.chan[i] = CH_RST;
      end
      s.gpio = ACG_GPIO_RESET;
      s.seq = SEQ_RST;
      s.mask = 16'h0001;
      return s;
   endfunction : reset_state

   // Elaboration check: the channel index is four bits wide
   if (NCH < 1 || NCH > 16) begin : g_bad_nch
      $error("acg_regs: NCH must lie between 1 and 16");
   end

   // Address decode
   logic ch_hit;
   logic [3:0] ch_sel;
   logic [7:0] ch_off;
   assign ch_off = bus_req.addr - ACG_CH_BASE;
   assign ch_sel = ch_off[3:0];
   assign ch_hit = bus_req.addr >= ACG_CH_BASE
      && bus_req.addr <= ACG_CH_LAST && int'(ch_off) < NCH;

   // Next enabled channel after the current one, wrapping round
   function automatic logic [3:0] next_channel(
      input acg_chan_t [NCH-1:0] ch, input logic [3:0] cur);
      logic [3:0] pick;
      int j;
      pick = cur;
      j = 0;
      for (int k = NCH; k >= 1; k--) begin
         j = (int'(cur) + k) % NCH;
         if (ch[j].en) begin
            pick = 4'(j);
         end
      end
      return pick;
   endfunction : next_channel

   // Readback of a pin bit: sampled level only while its input path is on
   function automatic logic [15:0] gpio_read(
      input acg_gpio_t g, input logic [1:0] lvl);
      acg_gpio_t r;
      r = g;
      if (g.pin1_input_enable) begin
         r.pin1_level = lvl[1];
      end
      if (g.pin0_input_enable) begin
         r.pin0_level = lvl[0];
      end
      return {10'h000, r};
   endfunction : gpio_read

   // Next state
   always_comb begin
      acg_chan_t w;
      st_d = st_q;
      w = bus_req.wdata;
      w.rsv = 2'h0;
      // Pin inputs pass two flops; only sync2 is read by logic
      st_d.sync1 = general_pin_in;
      st_d.sync2 = st_q.sync1;
      // Register writes; identification and unmapped addresses ignore them
      if (bus_req.wr) begin
         if (bus_req.addr == ACG_GPIO_ADDR) begin
            st_d.gpio = bus_req.wdata[5:0];
         end else if (ch_hit) begin
            st_d.chan[ch_sel] = w;
         end
      end
      // Sequencer steps on each finished conversion
      if (conv_done) begin
         st_d.cur = next_channel(st_q.chan, st_q.cur);
      end
      // Outputs toward the converter, one cycle behind the registers
      st_d.seq.channel = st_q.cur;
      st_d.seq.en = st_q.chan[st_q.cur].en;
      st_d.seq.setup = st_q.chan[st_q.cur].setup;
      st_d.seq.pair = st_q.chan[st_q.cur].pair;
      for (int i = 0; i < 16; i++) begin
         st_d.mask[i] = i < NCH ? st_q.chan[i].en : 1'b0;
      end
      // Pin drive follows the stored output enables and levels
      st_d.pin.oe = {st_q.gpio.pin1_output_enable,
         st_q.gpio.pin0_output_enable};
      st_d.pin.out = {st_q.gpio.pin1_level & st_q.gpio.pin1_output_enable,
         st_q.gpio.pin0_level & st_q.gpio.pin0_output_enable};
      // Read data stand for one cycle only, zero otherwise
      st_d.rdata = 16'h0000;
      if (bus_req.rd) begin
         if (bus_req.addr == ACG_GPIO_ADDR) begin
            st_d.rdata = gpio_read(st_q.gpio, st_q.sync2);
         end else if (bus_req.addr == ACG_ID_ADDR) begin
            st_d.rdata = {ID_VALUE[15:4], ACG_ID_DONT_CARE};
         end else if (ch_hit) begin
            st_d.rdata = st_q.chan[ch_sel];
         end
      end
   end

   // State register
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= reset_state();
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from flops
   assign reg_rdata = st_q.rdata;
   assign general_pin = st_q.pin;
   assign seq_now = st_q.seq;
   assign channel_enable_mask = st_q.mask; // Bit i mirrors channel i enable

   // Any channel enabled now; the registered mask lags a write by a cycle
   logic any_en;
   always_comb begin
      any_en = 1'b0;
      for (int i = 0; i < NCH; i++) begin
         any_en = any_en | st_q.chan[i].en;
      end
   end

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   chk_pin1_drive: assert property (
      bus_req.wr && bus_req.addr == ACG_GPIO_ADDR |=>
      ##1 general_pin.oe[1] == $past(bus_req.wdata[3], 2))
      else $error("pin one drive does not follow bit 3");

   chk_pin0_level: assert property (
      bus_req.wr && bus_req.addr == ACG_GPIO_ADDR && bus_req.wdata[2]
      |=> ##1 general_pin.out[0] == $past(bus_req.wdata[0], 2))
      else $error("pin zero level does not follow bit 0");

   chk_pin1_sample: assert property (
      bus_req.rd && bus_req.addr == ACG_GPIO_ADDR
      && st_q.gpio.pin1_input_enable |=> reg_rdata[1] == $past(st_q.sync2[1]))
      else $error("pin one readback is not the sampled level");

   chk_pin0_sample: assert property (
      bus_req.rd && bus_req.addr == ACG_GPIO_ADDR
      && st_q.gpio.pin0_input_enable |=> reg_rdata[0] == $past(st_q.sync2[0]))
      else $error("pin zero readback is not the sampled level");

   chk_pin_idle: assert property (
      !st_q.gpio.pin0_input_enable && !st_q.gpio.pin0_output_enable
      && !(bus_req.wr && bus_req.addr == ACG_GPIO_ADDR)
      |=> ##1 !general_pin.oe[0] && !general_pin.out[0])
      else $error("idle pin zero is driven");

   chk_id_read: assert property (
      bus_req.rd && bus_req.addr == ACG_ID_ADDR |=>
      reg_rdata == {ID_VALUE[15:4], ACG_ID_DONT_CARE})
      else $error("identification read returns a wrong value");

   chk_chan_write: assert property (
      bus_req.wr && ch_hit |=> st_q.chan[$past(ch_sel)] ==
      {$past(bus_req.wdata[15:12]), 2'h0, $past(bus_req.wdata[9:0])})
      else $error("channel write not stored with zero reserved bits");

   chk_chan_rsv: assert property (
      bus_req.rd && ch_hit |=> reg_rdata[11:10] == 2'h0)
      else $error("channel reserved bits read nonzero");

   chk_seq_step: assert property (
      conv_done && any_en && !bus_req.wr |=> st_q.chan[st_q.cur].en)
      else $error("sequencer stepped to a disabled channel");

   chk_seq_hold: assert property (
      !conv_done |=> $stable(st_q.cur))
      else $error("sequencer moved without a finished conversion");

   chk_setup_out: assert property (
      !conv_done && !bus_req.wr |=> ##1 seq_now.setup ==
      $past(st_q.chan[st_q.cur].setup, 2))
      else $error("setup output does not follow the current channel");

   // Read data port
   chk_rdata_idle: assert property (
      !bus_req.rd |=> reg_rdata == 16'h0000)
      else $error("read data present without a read strobe");

   chk_rdata_wr: assert property (
      bus_req.wr |=> reg_rdata == 16'h0000)
      else $error("read data present after a write");

   chk_unmapped_read: assert property (
      bus_req.rd && !ch_hit && bus_req.addr != ACG_GPIO_ADDR
      && bus_req.addr != ACG_ID_ADDR |=> reg_rdata == 16'h0000)
      else $error("unmapped read returns nonzero data");

   // General pin configuration
   chk_gpio_write: assert property (
      bus_req.wr && bus_req.addr == ACG_GPIO_ADDR |=>
      st_q.gpio == $past(bus_req.wdata[5:0]))
      else $error("pin configuration write not stored");

   chk_pin1_input: assert property (
      bus_req.wr && bus_req.addr == ACG_GPIO_ADDR |=>
      st_q.gpio.pin1_input_enable == $past(bus_req.wdata[5]))
      else $error("pin one input enable not stored");

   chk_pin0_input: assert property (
      bus_req.wr && bus_req.addr == ACG_GPIO_ADDR |=>
      st_q.gpio.pin0_input_enable == $past(bus_req.wdata[4]))
      else $error("pin zero input enable not stored");

   chk_pin0_drive: assert property (
      bus_req.wr && bus_req.addr == ACG_GPIO_ADDR |=>
      ##1 general_pin.oe[0] == $past(bus_req.wdata[2], 2))
      else $error("pin zero drive does not follow bit 2");

   chk_pin1_level: assert property (
      bus_req.wr && bus_req.addr == ACG_GPIO_ADDR && bus_req.wdata[3]
      |=> ##1 general_pin.out[1] == $past(bus_req.wdata[1], 2))
      else $error("pin one level does not follow bit 1");

   chk_pin1_off_low: assert property (
      !general_pin.oe[1] |-> !general_pin.out[1])
      else $error("pin one level shown while not driven");

   chk_pin0_off_low: assert property (
      !general_pin.oe[0] |-> !general_pin.out[0])
      else $error("pin zero level shown while not driven");

   chk_pin1_kept: assert property (
      bus_req.rd && bus_req.addr == ACG_GPIO_ADDR
      && !st_q.gpio.pin1_input_enable
      |=> reg_rdata[1] == $past(st_q.gpio.pin1_level))
      else $error("pin one readback lost the written level");

   chk_pin0_kept: assert property (
      bus_req.rd && bus_req.addr == ACG_GPIO_ADDR
      && !st_q.gpio.pin0_input_enable
      |=> reg_rdata[0] == $past(st_q.gpio.pin0_level))
      else $error("pin zero readback lost the written level");

   chk_gpio_rsv: assert property (
      bus_req.rd && bus_req.addr == ACG_GPIO_ADDR |=>
      reg_rdata[15:6] == 10'h000)
      else $error("pin configuration upper bits read nonzero");

   chk_gpio_dir: assert property (
      bus_req.rd && bus_req.addr == ACG_GPIO_ADDR |=>
      reg_rdata[5:2] == $past(st_q.gpio[5:2]))
      else $error("pin direction bits read back wrong");

   chk_gpio_kept: assert property (
      bus_req.wr && ch_hit |=> $stable(st_q.gpio))
      else $error("channel write disturbed the pin configuration");

   // Identification and channel registers
   chk_id_nowrite: assert property (
      bus_req.wr && bus_req.addr == ACG_ID_ADDR |=>
      $stable(st_q.chan) && $stable(st_q.gpio))
      else $error("identification write changed a register");

   chk_chan_read: assert property (
      bus_req.rd && ch_hit |=> reg_rdata == $past(st_q.chan[ch_sel]))
      else $error("channel read returns a wrong value");

   chk_chan_kept: assert property (
      bus_req.wr && bus_req.addr == ACG_GPIO_ADDR |=> $stable(st_q.chan))
      else $error("pin configuration write disturbed a channel");

   chk_setup_store: assert property (
      bus_req.wr && ch_hit |=> st_q.chan[$past(ch_sel)].setup ==
      $past(bus_req.wdata[14:12]))
      else $error("channel setup choice not stored");

   chk_pair_store: assert property (
      bus_req.wr && ch_hit |=> st_q.chan[$past(ch_sel)].pair ==
      $past(bus_req.wdata[9:0]))
      else $error("channel input pair not stored");

   chk_en_store: assert property (
      bus_req.wr && ch_hit |=> st_q.chan[$past(ch_sel)].en ==
      $past(bus_req.wdata[15]))
      else $error("channel enable not stored");

   chk_mask_low: assert property (
      1'b1 |=> channel_enable_mask[0] == $past(st_q.chan[0].en))
      else $error("enable mask bit 0 does not follow channel 0");

   chk_mask_top: assert property (
      1'b1 |=> channel_enable_mask[NCH-1] == $past(st_q.chan[NCH-1].en))
      else $error("enable mask top bit does not follow its channel");

   chk_mask_mid: assert property (
      1'b1 |=> channel_enable_mask[NCH/2] == $past(st_q.chan[NCH/2].en))
      else $error("enable mask middle bit does not follow its channel");

   // Sequencer outputs
   chk_seq_channel: assert property (
      1'b1 |=> seq_now.channel == $past(st_q.cur))
      else $error("channel output does not follow the current channel");

   chk_seq_en: assert property (
      1'b1 |=> seq_now.en == $past(st_q.chan[st_q.cur].en))
      else $error("enable output does not follow the current channel");

   chk_seq_setup_now: assert property (
      1'b1 |=> seq_now.setup == $past(st_q.chan[st_q.cur].setup))
      else $error("setup index does not follow the current channel");

   chk_seq_pair: assert property (
      !conv_done && !bus_req.wr |=> ##1 seq_now.pair ==
      $past(st_q.chan[st_q.cur].pair, 2))
      else $error("pair output does not follow the current channel");

   chk_seq_idle: assert property (
      conv_done && !any_en |=> $stable(st_q.cur))
      else $error("sequencer moved with no channel enabled");

   chk_cur_range: assert property (
      int'(st_q.cur) < NCH)
      else $error("current channel beyond the last channel");

endmodule : acg_regs

// ---- design/acg_pkg.sv ----
package acg_pkg;

   // Register map
   localparam logic [7:0] ACG_GPIO_ADDR = 8'h06;
   localparam logic [7:0] ACG_ID_ADDR = 8'h07;
   localparam logic [7:0] ACG_CH_BASE = 8'h10;
   localparam logic [7:0] ACG_CH_LAST = 8'h1F;

   // Reset values
   localparam logic [15:0] ACG_CH_RESET = 16'h8001;
   localparam logic [5:0] ACG_GPIO_RESET = 6'h00;
   localparam logic [3:0] ACG_ID_DONT_CARE = 4'h0;

   // Bus widths
   localparam int ACG_AW = 8;
   localparam int ACG_DW = 16;

   // Register bus request from the serial host side
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } acg_bus_req_t;

   // Channel register layout, bit 15 down to bit 0
   typedef struct packed {
      logic en;
      logic [2:0] setup;
      logic [1:0] rsv;
      logic [9:0] pair;
   } acg_chan_t;

   // General pin configuration, bit 5 down to bit 0
   typedef struct packed {
      logic pin1_input_enable;
      logic pin0_input_enable;
      logic pin1_output_enable;
      logic pin0_output_enable;
      logic pin1_level;
      logic pin0_level;
   } acg_gpio_t;

   // Drive toward the two general pins
   typedef struct packed {
      logic [1:0] out;
      logic [1:0] oe;
   } acg_pin_t;

   // What the conversion sequencer is working on now
   typedef struct packed {
      logic [3:0] channel;
      logic en;
      logic [2:0] setup;
      logic [9:0] pair;
   } acg_seq_t;

endpackage : acg_pkg

// ---- bench/acg_host.sv ----
`timescale 1ns/1ps
module acg_host (
   // Clock
   input wire logic sys_clk,
   // Register port toward the device
   output acg_pkg::acg_bus_req_t bus_req
);
   import acg_pkg::*;

   // Idle bus at time zero
   initial bus_req = '0;

   // One-cycle write, held through the sampling edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
      bus_req.wdata <= ~d; // Stale data must not look held
   endtask : wr

   // One-cycle read; the data are caught by the bench monitor
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
   endtask : rd
endmodule : acg_host

// ---- bench/test_adc_channel_gpio_id_regs.sv ----
`timescale 1ns/1ps
module test_adc_channel_gpio_id_regs;
   import acg_pkg::*;
   localparam logic [15:0] ID_V = 16'hC3A7; // Arbitrary identification value
   logic sys_clk, sys_rst, conv_done, rd_seen;
   logic [1:0] pin_in;
   logic [15:0] rdata, mask;
   acg_bus_req_t bus_req;
   acg_pin_t pins;
   acg_seq_t seq;
   logic [15:0] exp_q[$];
   logic [15:0] chv[16];
   int miscompares, checks;

   // 25 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   acg_regs #(.NCH(16), .ID_VALUE(ID_V)) acg_regs_inst (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .bus_req(bus_req), .reg_rdata(rdata),
      .general_pin_in(pin_in), .general_pin(pins), .conv_done(conv_done),
      .seq_now(seq), .channel_enable_mask(mask));
   acg_host acg_host_inst (.sys_clk(sys_clk), .bus_req(bus_req));

   task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic end_sim();
      $display("Checks %0d, miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim

   // Note the expectation first, so the monitor always finds it
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      acg_host_inst.rd(a);
   endtask : rd

   // One conversion done, then look at the sequencer three falling edges on
   task automatic step(input logic [3:0] c);
      @(posedge sys_clk) conv_done <= 1'b1;
      @(posedge sys_clk) conv_done <= 1'b0;
      repeat (3) @(negedge sys_clk);
      chk("sequencer", {c, 1'b1, chv[c][14:12], chv[c][9:0]}, seq);
   endtask : step

   // Read data stand only in the cycle after the strobe
   always @(posedge sys_clk) rd_seen <= bus_req.rd;
   always @(negedge sys_clk) begin
      if (rd_seen === 1'b1) begin
         if (exp_q.size() == 0)
            chk("unexpected read", 32'h0, 32'h1);
         else
            chk("read data", exp_q.pop_front(), rdata);
      end
   end

   // Guard against a hang
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      end_sim();
   end

   initial begin
      sys_rst = 1'b1;
      conv_done = 1'b0;
      pin_in = 2'b00;
      miscompares = 0;
      checks = 0;
      void'($urandom(2960));
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      // Reset state, identification and a hole in the map
      @(negedge sys_clk) chk("reset mask", 16'h0001, mask);
      rd(ACG_ID_ADDR, ID_V & 16'hFFF0);
      rd(ACG_GPIO_ADDR, 16'h0000);
      for (int i = 0; i < 16; i++) rd(ACG_CH_BASE + 8'(i), ACG_CH_RESET);
      rd(8'h08, 16'h0000);
      acg_host_inst.wr(ACG_ID_ADDR, ~ID_V);
      rd(ACG_ID_ADDR, ID_V & 16'hFFF0);
      // Random channel contents, setups 0..7 all used, only 0 and 3 on
      for (int i = 0; i < 16; i++) begin
         chv[i] = (16'($urandom) & 16'h0FFF) | (16'(i % 8) << 12);
         if (i == 0 || i == 3) chv[i][15] = 1'b1;
         acg_host_inst.wr(ACG_CH_BASE + 8'(i), chv[i]);
         rd(ACG_CH_BASE + 8'(i), chv[i] & 16'hF3FF);
      end
      repeat (2) @(negedge sys_clk);
      chk("enable mask", 16'h0009, mask);
      // Step from channel 0 to 3, then wrap from the last enabled channel back to the first
      step(4'd3);
      step(4'd0);
      // Both pins driven, then one released
      acg_host_inst.wr(ACG_GPIO_ADDR, 16'h000E);
      repeat (3) @(negedge sys_clk);
      chk("pin drive", 4'b1011, pins);
      acg_host_inst.wr(ACG_GPIO_ADDR, 16'h0009);
      repeat (3) @(negedge sys_clk);
      chk("pin drive", 4'b0010, pins);
      // Inputs: readback shows the pin levels
      pin_in <= 2'b10;
      acg_host_inst.wr(ACG_GPIO_ADDR, 16'h0030);
      repeat (3) @(posedge sys_clk);
      rd(ACG_GPIO_ADDR, 16'h0032);
      chk("pin drive", 4'b0000, pins);
      // Neither direction: stored bits kept, nothing driven
      pin_in <= 2'b01;
      acg_host_inst.wr(ACG_GPIO_ADDR, 16'hFFC2);
      repeat (3) @(posedge sys_clk);
      rd(ACG_GPIO_ADDR, 16'h0002);
      chk("pin drive", 4'b0000, pins);
      repeat (3) @(posedge sys_clk);
      end_sim();
   end
endmodule : test_adc_channel_gpio_id_regs
